// ==== design/scb_pkg.sv ====
package scb_pkg;
  // ==========================================================
  // Device register map
  // ==========================================================
  localparam logic [31:0] APP_CTRL_ADDR   = 32'hE000ED0C;
  localparam logic [31:0] SLEEP_CTRL_ADDR = 32'hE000ED10;
  localparam logic [31:0] DBG_STATUS_ADDR = 32'hE000EDF0;
  localparam logic [15:0] KEY_WRITE       = 16'h05FA;
  localparam logic [15:0] KEY_READ        = 16'hFA05;
  localparam int          KEY_LSB         = 16;
  localparam int          BYTE_ORDER_BIT  = 15;
  localparam int          SPLIT_LSB       = 8;
  localparam int          SPLIT_W         = 3;
  localparam logic [2:0]  SPLIT_RESET     = 3'h0;
  localparam int          SYS_RST_BIT     = 2;
  localparam int          CLR_ACT_BIT     = 1;
  localparam int          CORE_RST_BIT    = 0;
  localparam int          SEV_BIT         = 4;
  localparam int          DEEP_BIT        = 2;
  localparam int          EXIT_BIT        = 1;
  localparam int          SLEEPING_BIT    = 0;
  localparam int          HALTED_BIT      = 1;
  localparam logic [1:0]  STRAP_WAIT      = 2'h2;
  // ==========================================================
  // Controller register map
  // ==========================================================
  localparam int          HOST_AW         = 5;
  localparam logic [4:0]  H_ADDR_OFS      = 5'h00;
  localparam logic [4:0]  H_WDATA_OFS     = 5'h04;
  localparam logic [4:0]  H_CMD_OFS       = 5'h08;
  localparam logic [4:0]  H_STATUS_OFS    = 5'h0C;
  localparam logic [4:0]  H_RDATA_OFS     = 5'h10;
  localparam int          CMD_WR_BIT      = 0;
  localparam int          CMD_RD_BIT      = 1;
  localparam int          ST_BUSY_BIT     = 0;
  localparam int          ST_REFUSED_BIT  = 1;
  localparam int          ST_REQ_BIT      = 2;
  localparam int          ST_LRST_BIT     = 3;
  localparam logic [1:0]  AXI_OKAY        = 2'h0;
  localparam int          LOCAL_RESET_CYCLES = 8;
endpackage : scb_pkg

// ==== design/scb_link_if.sv ====
`timescale 1ns/10ps
interface scb_link_if;
  logic        wr;
  logic        rd;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        ack;
  logic        sys_reset_req;
  logic        local_reset;

  modport dev (
    input  wr, rd, addr, wdata, local_reset,
    output rdata, ack, sys_reset_req
  );
  modport host (
    output wr, rd, addr, wdata, local_reset,
    input  rdata, ack, sys_reset_req
  );
endinterface : scb_link_if

// ==== design/scb_device.sv ====
`timescale 1ns/10ps
module scb_device
  import scb_pkg::*;
#(
  parameter int IRQ_COUNT = 8
) (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  scb_link_if.dev                   link,
  input  wire logic                 i_byte_order_strap,
  input  wire logic [IRQ_COUNT-1:0] i_irq_pending,
  input  wire logic                 i_handler_exit,
  input  wire logic                 i_exit_to_base,
  input  wire logic                 i_core_sleeping,
  input  wire logic                 i_core_halted,
  output logic                      o_clear_active,
  output logic                      o_core_reset,
  output logic                      o_wake_event,
  output logic                      o_sleep_on_exit,
  output logic                      o_deep_sleep,
  output logic                      o_byte_order,
  output logic [SPLIT_W-1:0]        o_split_point
);

  // ==========================================================
  // Parameter check
  // ==========================================================
  generate
    if (IRQ_COUNT < 1) begin : g_bad_count
      $error("IRQ_COUNT must be at least one");
    end
  endgenerate

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [1:0]           strap_sync;
    logic [1:0]           strap_cnt;
    logic                 byte_order;
    logic [SPLIT_W-1:0]   split;
    logic                 sys_req;
    logic                 clr_pulse;
    logic                 core_pulse;
    logic                 sev;
    logic                 deep;
    logic                 on_exit;
    logic [IRQ_COUNT-1:0] pend_prev;
    logic                 wake;
    logic                 exit_sleep;
    logic                 ack;
    logic [31:0]          rdata;
  } dev_state_s;

  dev_state_s st_r;
  dev_state_s st_nxt;

  logic        key_ok;
  logic        app_wr;
  logic        sleep_wr;
  logic [31:0] app_view;
  logic [31:0] sleep_view;
  logic [31:0] dbg_view;

  assign key_ok   = link.wdata[31:KEY_LSB] == KEY_WRITE;
  assign app_wr   = link.wr && (link.addr == APP_CTRL_ADDR) && key_ok;
  assign sleep_wr = link.wr && (link.addr == SLEEP_CTRL_ADDR);

  // ==========================================================
  // Read views
  // ==========================================================
  always_comb begin
    app_view                              = 32'h0000_0000;
    app_view[31:KEY_LSB]                  = KEY_READ;
    app_view[BYTE_ORDER_BIT]              = st_r.byte_order;
    app_view[SPLIT_LSB +: SPLIT_W]        = st_r.split;
    sleep_view                            = 32'h0000_0000;
    sleep_view[SEV_BIT]                   = st_r.sev;
    sleep_view[DEEP_BIT]                  = st_r.deep;
    sleep_view[EXIT_BIT]                  = st_r.on_exit;
    dbg_view                              = 32'h0000_0000;
    dbg_view[SLEEPING_BIT]                = i_core_sleeping;
    dbg_view[HALTED_BIT]                  = i_core_halted;
  end

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    st_nxt = st_r;

    // Strap sampled once, after it has passed the synchroniser
    st_nxt.strap_sync = {st_r.strap_sync[0], i_byte_order_strap};
    if (st_r.strap_cnt != STRAP_WAIT + 2'h1) begin
      st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
      if (st_r.strap_cnt == STRAP_WAIT) begin
        st_nxt.byte_order = st_r.strap_sync[1];
      end
    end

    st_nxt.clr_pulse = 1'b0;
    st_nxt.core_pulse = 1'b0;
    st_nxt.ack = link.wr || link.rd;

    // Wake on a fresh pending edge of any interrupt
    st_nxt.pend_prev = i_irq_pending;
    st_nxt.wake = st_r.sev && (|(i_irq_pending & ~st_r.pend_prev));
    st_nxt.exit_sleep = st_r.on_exit && i_handler_exit && i_exit_to_base;

    if (app_wr) begin
      st_nxt.split = link.wdata[SPLIT_LSB +: SPLIT_W];
      if (link.wdata[SYS_RST_BIT]) begin
        st_nxt.sys_req = 1'b1;
      end
      st_nxt.clr_pulse = link.wdata[CLR_ACT_BIT];
      st_nxt.core_pulse = link.wdata[CORE_RST_BIT];
    end

    if (sleep_wr) begin
      st_nxt.sev = link.wdata[SEV_BIT];
      st_nxt.deep = link.wdata[DEEP_BIT];
      st_nxt.on_exit = link.wdata[EXIT_BIT];
    end

    if (link.rd) begin
      unique case (link.addr)
        APP_CTRL_ADDR:   st_nxt.rdata = app_view;
        SLEEP_CTRL_ADDR: st_nxt.rdata = sleep_view;
        DBG_STATUS_ADDR: st_nxt.rdata = dbg_view;
        default:         st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Local reset from the external controller ends the request
    if (link.local_reset) begin
      st_nxt.sys_req = 1'b0;
      st_nxt.split = SPLIT_RESET;
      st_nxt.sev = 1'b0;
      st_nxt.deep = 1'b0;
      st_nxt.on_exit = 1'b0;
      st_nxt.clr_pulse = 1'b0;
      st_nxt.core_pulse = 1'b0;
      st_nxt.wake = 1'b0;
      st_nxt.exit_sleep = 1'b0;
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign link.rdata         = st_r.rdata;
  assign link.ack           = st_r.ack;
  assign link.sys_reset_req = st_r.sys_req;
  assign o_clear_active     = st_r.clr_pulse;
  assign o_core_reset       = st_r.core_pulse;
  assign o_wake_event       = st_r.wake;
  assign o_sleep_on_exit    = st_r.exit_sleep;
  assign o_deep_sleep       = st_r.deep;
  assign o_byte_order       = st_r.byte_order;
  assign o_split_point      = st_r.split;

endmodule : scb_device

// ==== design/scb_host.sv ====
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
module scb_host
  import scb_pkg::*;
#(
  parameter int RESET_CYCLES = LOCAL_RESET_CYCLES
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  scb_link_if.host                link,
  input  wire logic               i_core_halted,
  output logic                    o_local_reset,
  input  wire logic               i_awvalid,
  output logic                    o_awready,
  input  wire logic [HOST_AW-1:0] i_awaddr,
  input  wire logic               i_wvalid,
  output logic                    o_wready,
  input  wire logic [31:0]        i_wdata,
  input  wire logic [3:0]         i_wstrb,
  output logic                    o_bvalid,
  input  wire logic               i_bready,
  output logic [1:0]              o_bresp,
  input  wire logic               i_arvalid,
  output logic                    o_arready,
  input  wire logic [HOST_AW-1:0] i_araddr,
  output logic                    o_rvalid,
  input  wire logic               i_rready,
  output logic [31:0]             o_rdata,
  output logic [1:0]              o_rresp
);

  generate
    if (RESET_CYCLES < 1 || RESET_CYCLES > 255) begin : g_bad_cycles
      $error("RESET_CYCLES must lie in 1..255");
    end
  endgenerate

  localparam logic [7:0] RST_LEN = 8'(RESET_CYCLES);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic               aw_got;
    logic               w_got;
    logic [HOST_AW-1:0] awaddr;
    logic [31:0]        wbuf;
    logic [3:0]         wstrb;
    logic               bvalid;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [31:0]        l_addr;
    logic [31:0]        l_wdata;
    logic [31:0]        l_rdata;
    logic               busy;
    logic               rd_pend;
    logic               lwr;
    logic               lrd;
    logic               refused;
    logic               lrst;
    logic [7:0]         rst_cnt;
  } host_state_s;

  host_state_s st_r;
  host_state_s st_nxt;

  logic        aw_go;
  logic        w_go;
  logic        commit;
  logic        bad_cmd;
  logic [31:0] status;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  assign o_awready = !st_r.aw_got && !st_r.bvalid;
  assign o_wready  = !st_r.w_got && !st_r.bvalid;
  assign o_arready = !st_r.rvalid;
  assign aw_go     = i_awvalid && o_awready;
  assign w_go      = i_wvalid && o_wready;
  assign commit    = st_r.aw_got && st_r.w_got && !st_r.bvalid;

  // Command refused if it breaks the writer's obligations
  always_comb begin
    bad_cmd = 1'b0;
    if (st_r.l_addr == APP_CTRL_ADDR && st_r.l_wdata[31:KEY_LSB] == KEY_WRITE) begin
      if ((st_r.l_wdata[CLR_ACT_BIT] || st_r.l_wdata[CORE_RST_BIT]) && !i_core_halted) begin
        bad_cmd = 1'b1;
      end
      if (st_r.l_wdata[CORE_RST_BIT] && st_r.l_wdata[SYS_RST_BIT]) begin
        bad_cmd = 1'b1;
      end
    end
    status                 = 32'h0000_0000;
    status[ST_BUSY_BIT]    = st_r.busy;
    status[ST_REFUSED_BIT] = st_r.refused;
    status[ST_REQ_BIT]     = link.sys_reset_req;
    status[ST_LRST_BIT]    = st_r.lrst;
  end

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    st_nxt = st_r;
    st_nxt.lwr = 1'b0;
    st_nxt.lrd = 1'b0;
    if (aw_go) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = i_awaddr;
    end
    if (w_go) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wbuf = i_wdata;
      st_nxt.wstrb = i_wstrb;
    end
    if (st_r.bvalid && i_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.busy && link.ack) begin
      st_nxt.busy = 1'b0;
      st_nxt.rd_pend = 1'b0;
      if (st_r.rd_pend) begin
        st_nxt.l_rdata = link.rdata;
      end
    end
    if (commit) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      unique case (st_r.awaddr)
        H_ADDR_OFS:  st_nxt.l_addr = merge(st_r.l_addr, st_r.wbuf, st_r.wstrb);
        H_WDATA_OFS: st_nxt.l_wdata = merge(st_r.l_wdata, st_r.wbuf, st_r.wstrb);
        H_CMD_OFS: begin
          if (st_r.wstrb[0] && (st_r.wbuf[CMD_WR_BIT] || st_r.wbuf[CMD_RD_BIT])) begin
            if (st_r.busy || (st_r.wbuf[CMD_WR_BIT] && st_r.wbuf[CMD_RD_BIT])
                || (st_r.wbuf[CMD_WR_BIT] && bad_cmd) || st_r.lrst) begin
              st_nxt.refused = 1'b1;
            end else begin
              st_nxt.busy = 1'b1;
              st_nxt.lwr = st_r.wbuf[CMD_WR_BIT];
              st_nxt.lrd = st_r.wbuf[CMD_RD_BIT];
              st_nxt.rd_pend = st_r.wbuf[CMD_RD_BIT];
            end
          end
        end
        H_STATUS_OFS: begin
          // Write one clears the refused flag
          if (st_r.wstrb[0] && st_r.wbuf[ST_REFUSED_BIT]) begin
            st_nxt.refused = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (i_arvalid && o_arready) begin
      st_nxt.rvalid = 1'b1;
      unique case (i_araddr)
        H_ADDR_OFS:   st_nxt.rdata = st_r.l_addr;
        H_WDATA_OFS:  st_nxt.rdata = st_r.l_wdata;
        H_STATUS_OFS: st_nxt.rdata = status;
        H_RDATA_OFS:  st_nxt.rdata = st_r.l_rdata;
        default:      st_nxt.rdata = 32'h0000_0000;
      endcase
    end else if (st_r.rvalid && i_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    // Answer a reset request with a local reset of fixed length
    if (st_r.lrst) begin
      st_nxt.rst_cnt = st_r.rst_cnt - 8'h01;
      if (st_r.rst_cnt == 8'h01) begin
        st_nxt.lrst = 1'b0;
      end
    end else if (link.sys_reset_req) begin
      st_nxt.lrst = 1'b1;
      st_nxt.rst_cnt = RST_LEN;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign link.wr          = st_r.lwr;
  assign link.rd          = st_r.lrd;
  assign link.addr        = st_r.l_addr;
  assign link.wdata       = st_r.l_wdata;
  assign link.local_reset = st_r.lrst;
  assign o_local_reset    = st_r.lrst;
  assign o_bvalid         = st_r.bvalid;
  assign o_bresp          = AXI_OKAY;
  assign o_rvalid         = st_r.rvalid;
  assign o_rdata          = st_r.rdata;
  assign o_rresp          = AXI_OKAY;

endmodule : scb_host

// ==== tb/scb_props.sv ====
`timescale 1ns/10ps
module scb_props
  import scb_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        ack,
  input wire logic        sys_reset_req,
  input wire logic        local_reset
);
  // ==========================================================
  // Sequences
  // ==========================================================
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence app_wr_s;
    wr && addr == APP_CTRL_ADDR && !local_reset;
  endsequence
  sequence keyed_req_s;
    app_wr_s ##0 (wdata[31:16] == KEY_WRITE && wdata[SYS_RST_BIT]);
  endsequence
  sequence app_rd_s;
    rd && addr == APP_CTRL_ADDR;
  endsequence
  sequence sleep_rd_s;
    rd && addr == SLEEP_CTRL_ADDR;
  endsequence
  // ==========================================================
  // Properties
  // ==========================================================
  ack_timing_a: assert property ((wr || rd) |=> ack)
    else $error("ack missing after request");
  ack_cause_a: assert property (ack |-> $past(wr) || $past(rd))
    else $error("ack without request");
  key_readback_a: assert property (app_rd_s |=> rdata[31:16] == KEY_READ)
    else $error("key readback wrong");
  app_reserved_a: assert property (app_rd_s |=> rdata[14:11] == 4'h0 && rdata[7:0] == 8'h00)
    else $error("reserved control bits not zero");
  sleep_reserved_a: assert property (sleep_rd_s |=> (rdata & ~32'h0000_0016) == 32'h0)
    else $error("reserved sleep bits not zero");
  req_raise_a: assert property (keyed_req_s |=> sys_reset_req)
    else $error("reset request not raised");
  bad_key_a: assert property (app_wr_s ##0 (wdata[31:16] != KEY_WRITE && !sys_reset_req)
    |=> !sys_reset_req)
    else $error("unkeyed write changed request");
  req_hold_a: assert property (sys_reset_req && !local_reset |=> sys_reset_req)
    else $error("reset request dropped early");
  req_drop_a: assert property (local_reset |=> !sys_reset_req)
    else $error("reset request not cleared");
endmodule : scb_props

// ==== tb/system_reset_sleep_control_tb.sv ====
`timescale 1ns/10ps
module system_reset_sleep_control_tb;
  import scb_pkg::*;
  typedef struct packed {logic [31:0] a; logic [31:0] d; logic [31:0] e;} row_s;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_core_halted = 1'b0, i_handler_exit = 1'b0;
  logic i_exit_to_base = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic i_arvalid = 1'b0, i_rready = 1'b0;
  logic i_byte_order_strap = 1'b1, i_core_sleeping = 1'b1;
  logic [7:0] i_irq_pending = 8'h00;
  logic [4:0] i_awaddr = 5'h00, i_araddr = 5'h00;
  logic [31:0] i_wdata = 32'h0, v;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_local_reset, o_clear_active;
  logic o_core_reset, o_wake_event, o_sleep_on_exit, o_deep_sleep, o_byte_order;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [2:0] o_split_point;
  int n_errors = 0, n_compared = 0, cyc = 0, n_clr = 0, n_crst = 0, n_wake = 0, n_soe = 0;
  int n_lrst = 0, lr0;
  row_s rows[7] = '{'{APP_CTRL_ADDR, 32'h05FA_0500, 32'hFA05_8500},
    '{APP_CTRL_ADDR, 32'h1234_0300, 32'hFA05_8500}, '{APP_CTRL_ADDR, 32'h05FA_FFF8, 32'hFA05_8700},
    '{SLEEP_CTRL_ADDR, 32'hFFFF_FFFF, 32'h0000_0016}, '{SLEEP_CTRL_ADDR, 32'h4, 32'h4},
    '{DBG_STATUS_ADDR, 32'hFFFF_FFFF, 32'h1}, '{32'hE000_ED14, 32'hFFFF_FFFF, 32'h0}};
  scb_link_if link ();
  scb_host #(.RESET_CYCLES(2)) u_scb_host (.i_ref_clk, .i_rst, .link, .i_core_halted,
    .o_local_reset, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata,
    .i_wstrb(4'hF), .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr,
    .o_rvalid, .i_rready, .o_rdata, .o_rresp);
  scb_device u_scb_device (.i_ref_clk, .i_rst, .link, .i_byte_order_strap,
    .i_irq_pending, .i_handler_exit, .i_exit_to_base, .i_core_sleeping, .i_core_halted,
    .o_clear_active, .o_core_reset, .o_wake_event, .o_sleep_on_exit, .o_deep_sleep,
    .o_byte_order, .o_split_point);
  scb_props u_scb_props (.i_ref_clk, .i_rst, .wr(link.wr), .rd(link.rd), .addr(link.addr),
    .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
    .sys_reset_req(link.sys_reset_req), .local_reset(link.local_reset));
  always #5 i_ref_clk = ~i_ref_clk;
  // ==========================================================
  // Pulse counters and timeout
  // ==========================================================
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    n_clr <= n_clr + o_clear_active;
    n_crst <= n_crst + o_core_reset;
    n_wake <= n_wake + o_wake_event;
    n_soe <= n_soe + o_sleep_on_exit;
    n_lrst <= n_lrst + o_local_reset;
    if (cyc == 30000) begin
      n_errors = n_errors + 1;
      results();
    end
  end
  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    logic [1:0] resp;
    @(posedge i_ref_clk);
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_awaddr <= a;
    i_wdata <= d;
    i_bready <= 1'b1;
    do begin
      @(negedge i_ref_clk);
      aw_hs = i_awvalid & o_awready;
      w_hs = i_wvalid & o_wready;
      b_hs = o_bvalid;
      resp = o_bresp;
      @(posedge i_ref_clk);
      if (aw_hs) i_awvalid <= 1'b0;
      if (w_hs) i_wvalid <= 1'b0;
    end while (b_hs !== 1'b1);
    i_bready <= 1'b0;
    check({30'h0, resp}, {30'h0, AXI_OKAY});
  endtask : axi_wr
  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d);
    logic ar_hs, r_hs;
    logic [1:0] resp;
    @(posedge i_ref_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    do begin
      @(negedge i_ref_clk);
      ar_hs = i_arvalid & o_arready;
      r_hs = o_rvalid;
      d = o_rdata;
      resp = o_rresp;
      @(posedge i_ref_clk);
      if (ar_hs) i_arvalid <= 1'b0;
    end while (r_hs !== 1'b1);
    i_rready <= 1'b0;
    check({30'h0, resp}, {30'h0, AXI_OKAY});
  endtask : axi_rd
  task automatic dev_op(input logic [31:0] a, input logic [31:0] d, input logic [31:0] cmd);
    logic [31:0] st;
    axi_wr(H_ADDR_OFS, a);
    axi_wr(H_WDATA_OFS, d);
    axi_wr(H_CMD_OFS, cmd);
    do axi_rd(H_STATUS_OFS, st); while (st[ST_BUSY_BIT] !== 1'b0);
  endtask : dev_op
  task automatic dev_rd(input logic [31:0] a, output logic [31:0] d);
    dev_op(a, 32'h0, 32'h2);
    axi_rd(H_RDATA_OFS, d);
  endtask : dev_rd
  task automatic refused_chk();
    logic [31:0] st;
    axi_rd(H_STATUS_OFS, st);
    check(st & 32'h2, 32'h2);
    axi_wr(H_STATUS_OFS, 32'h2);
    axi_rd(H_STATUS_OFS, st);
    check(st & 32'h2, 32'h0);
  endtask : refused_chk
  task automatic results();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    check({31'h0, o_byte_order}, 32'h1);
    i_byte_order_strap <= 1'b0;
    foreach (rows[i]) begin
      dev_op(rows[i].a, rows[i].d, 32'h1);
      dev_rd(rows[i].a, v);
      check(v, rows[i].e);
    end
    check({28'h0, o_deep_sleep, o_split_point}, 32'hF);
    i_irq_pending <= 8'h01;
    repeat (3) @(posedge i_ref_clk);
    check(n_wake, 0);
    dev_op(SLEEP_CTRL_ADDR, 32'h12, 32'h1);
    i_irq_pending <= 8'h03;
    repeat (3) @(posedge i_ref_clk);
    check(n_wake, 1);
    i_handler_exit <= 1'b1;
    @(posedge i_ref_clk);
    i_handler_exit <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    check(n_soe, 0);
    i_exit_to_base <= 1'b1;
    i_handler_exit <= 1'b1;
    @(posedge i_ref_clk);
    i_handler_exit <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    check(n_soe, 1);
    dev_op(APP_CTRL_ADDR, 32'h05FA_0702, 32'h1);
    check(n_clr, 0);
    refused_chk();
    i_core_halted <= 1'b1;
    dev_op(APP_CTRL_ADDR, 32'h05FA_0702, 32'h1);
    check(n_clr, 1);
    dev_op(APP_CTRL_ADDR, 32'h05FA_0705, 32'h1);
    check(n_crst, 0);
    refused_chk();
    dev_op(APP_CTRL_ADDR, 32'h05FA_0701, 32'h1);
    check(n_crst, 1);
    i_core_sleeping <= 1'b0;
    dev_rd(DBG_STATUS_ADDR, v);
    check(v, 32'h2);
    repeat (12) @(posedge i_ref_clk);
    lr0 = n_lrst;
    dev_op(APP_CTRL_ADDR, 32'h05FA_0704, 32'h1);
    do axi_rd(H_STATUS_OFS, v); while ((v & 32'hC) !== 32'h0);
    check(n_lrst - lr0, 2);
    dev_rd(APP_CTRL_ADDR, v);
    check(v, 32'hFA05_8000);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    check({31'h0, o_byte_order}, 32'h0);
    dev_rd(APP_CTRL_ADDR, v);
    check(v, 32'hFA05_0000);
    results();
  end
endmodule : system_reset_sleep_control_tb
